//--- hdl/ahl_map.svh
// Purpose: Serial port settings, reset values and timing counts of the host link
// Assumes: Included by the package and by every design file
// Notes:   Definitions only
`ifndef AHL_MAP_SVH
`define AHL_MAP_SVH

// --------------------------------------------------------------
// Clock and timing
// --------------------------------------------------------------
`define AHL_MCLK_PERIOD_PS    5000
`define AHL_POR_TIME_US       250
`define AHL_REGACQ_TIME_US    5
`define AHL_SYNC_MAX_PERIODS  2047
`define AHL_RESET_MIN_PERIODS 2048
`define AHL_RDY_HIGH_PERIODS  4
`define AHL_RDY_LOW_PERIODS   4

// --------------------------------------------------------------
// Serial port
// --------------------------------------------------------------
`define AHL_CPOL              1'b0
`define AHL_CPHA              1'b1
`define AHL_WORD_BITS         16
`define AHL_BUF_DEPTH         2

// Pin sampler reset: sclk 0, csN 1, din 0, mclkIn 0, syncRstN 1
`define AHL_PINS_RST          5'h09

`endif

//--- hdl/ahl_pkg.sv
// Purpose: Types shared by the host link files
// Assumes: ahl_map.svh on the include path
// Notes:   Nothing is imported; users write ahl_pkg::name
package ahl_pkg;
`include "ahl_map.svh"

   // -----------------------------------------------------------
   // State types
   // -----------------------------------------------------------
   typedef enum logic [1:0] {RS_IDLE, RS_LOW, RS_RESET} ahl_rst_t;
   typedef enum logic [1:0] {PW_POR, PW_REGLOAD, PW_READY} ahl_pwr_t;
   typedef enum logic [1:0] {DR_IDLE, DR_HIGH, DR_LOW} ahl_sample_ready_flag_t;

   // -----------------------------------------------------------
   // Carriers
   // -----------------------------------------------------------
   typedef struct packed {
      logic                      first;
      logic [`AHL_WORD_BITS-1:0] data;
   } ahl_word_t;

   typedef struct packed {
      logic sclk;
      logic csN;
      logic din;
      logic mclkIn;
      logic syncRstN;
   } ahl_pins_t;
endpackage

//--- hdl/ahl_word_buf.sv
// Purpose: Two-entry buffer for received words
// Assumes: Single clock, flush resets pointers and count
// Notes:   Valid and ready on both sides
`timescale 1ns/1ps
`include "ahl_map.svh"
module ahl_word_buf (
   input  wire logic              mclk,
   input  wire logic              reset,
   input  wire logic              flush,
   input  wire logic              inValid,
   output      logic              inReady,
   input  ahl_pkg::ahl_word_t     inWord,
   output      logic              outValid,
   input  wire logic              outReady,
   output ahl_pkg::ahl_word_t     outWord
);
   localparam int DEPTH = `AHL_BUF_DEPTH;

   ahl_pkg::ahl_word_t mem_r   [0:DEPTH-1];
   ahl_pkg::ahl_word_t mem_nxt [0:DEPTH-1];
   logic               wrPtr_r, wrPtr_nxt;
   logic               rdPtr_r, rdPtr_nxt;
   logic [1:0]         cnt_r, cnt_nxt;
   logic               push, pop;

   assign inReady  = (cnt_r != 2'(DEPTH));
   assign outValid = (cnt_r != 2'h0);
   assign outWord  = mem_r[rdPtr_r];
   assign push     = inValid & inReady;
   assign pop      = outValid & outReady;

   // -----------------------------------------------------------
   // Next state
   // -----------------------------------------------------------
   always_comb begin
      mem_nxt   = mem_r;
      wrPtr_nxt = wrPtr_r;
      rdPtr_nxt = rdPtr_r;
      cnt_nxt   = cnt_r;
      if (flush) begin
         wrPtr_nxt = 1'b0;
         rdPtr_nxt = 1'b0;
         cnt_nxt   = 2'h0;
      end else begin
         if (push) begin
            mem_nxt[wrPtr_r] = inWord;
            wrPtr_nxt        = ~wrPtr_r;
         end
         if (pop) begin
            rdPtr_nxt = ~rdPtr_r;
         end
         if (push && !pop) begin
            cnt_nxt = cnt_r + 2'h1;
         end else if (pop && !push) begin
            cnt_nxt = cnt_r - 2'h1;
         end
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
         wrPtr_r <= 1'b0;
         rdPtr_r <= 1'b0;
         cnt_r   <= 2'h0;
      end else begin
         mem_r   <= mem_nxt;
         wrPtr_r <= wrPtr_nxt;
         rdPtr_r <= rdPtr_nxt;
         cnt_r   <= cnt_nxt;
      end
   end
endmodule // ahl_word_buf

//--- hdl/ahl_host_link.sv
// Purpose: Host serial port, sync/restart pin and ready pulse timing
// Assumes: All pins asynchronous to mclk (200 MHz)
// Notes:
`timescale 1ns/1ps
`include "ahl_map.svh"
module ahl_host_link #(
   parameter int POR_CYCLES =
      (`AHL_POR_TIME_US * 1000000) / `AHL_MCLK_PERIOD_PS
) (
   input  wire logic                      mclk,
   input  wire logic                      reset,
   input  wire logic                      mclkInPin,
   input  wire logic                      syncRstNPin,
   input  wire logic                      sclkPin,
   input  wire logic                      csNPin,
   input  wire logic                      dinPin,
   output      logic                      doutO,
   output      logic                      doutOeN,
   output      logic                      sampleReadyFlag,
   input  wire logic                      convDone,
   input  wire logic [`AHL_WORD_BITS-1:0] txWord,
   input  wire logic                      txValid,
   output      logic                      txReady,
   output ahl_pkg::ahl_word_t             rxWord,
   output      logic                      rxValid,
   input  wire logic                      rxReady,
   output      logic                      syncPulse,
   output      logic                      deviceResetting,
   output      logic                      linkReady,
   output      logic                      rxOverrun
);
   localparam int WB = `AHL_WORD_BITS;
   localparam int ACQ_CYCLES =
      (`AHL_REGACQ_TIME_US * 1000000) / `AHL_MCLK_PERIOD_PS;
   localparam logic [11:0] RST_LAST = 12'(`AHL_RESET_MIN_PERIODS - 1);
   localparam logic [11:0] RST_FULL = 12'(`AHL_RESET_MIN_PERIODS);
   localparam logic [16:0] POR_LAST = 17'(POR_CYCLES - 1);
   localparam logic [16:0] ACQ_LAST = 17'(ACQ_CYCLES - 1);
   localparam logic [2:0]  HI_LAST  = 3'(`AHL_RDY_HIGH_PERIODS - 1);
   localparam logic [2:0]  LO_LAST  = 3'(`AHL_RDY_LOW_PERIODS - 1);
   localparam logic [3:0]  BIT_LAST = 4'(WB - 1);

   // -----------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------
   ahl_pkg::ahl_pins_t pinsIn, pinsMeta_r, pinsSync_r, pinsLast_r;
   logic mclkInFall, leadEdge, trailEdge, launchEdge, captureEdge;
   logic csFall;

   assign pinsIn = '{sclk: sclkPin, csN: csNPin, din: dinPin,
                     mclkIn: mclkInPin, syncRstN: syncRstNPin};

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pinsMeta_r <= `AHL_PINS_RST;
         pinsSync_r <= `AHL_PINS_RST;
         pinsLast_r <= `AHL_PINS_RST;
      end else begin
         pinsMeta_r <= pinsIn;
         pinsSync_r <= pinsMeta_r;
         pinsLast_r <= pinsSync_r;
      end
   end

   assign mclkInFall = pinsLast_r.mclkIn & ~pinsSync_r.mclkIn;
   assign leadEdge   = (pinsSync_r.sclk != `AHL_CPOL) &&
                       (pinsLast_r.sclk == `AHL_CPOL);
   assign trailEdge  = (pinsSync_r.sclk == `AHL_CPOL) &&
                       (pinsLast_r.sclk != `AHL_CPOL);
   assign launchEdge  = `AHL_CPHA ? leadEdge : trailEdge;
   assign captureEdge = `AHL_CPHA ? trailEdge : leadEdge;
   assign csFall     = pinsLast_r.csN & ~pinsSync_r.csN;

   // -----------------------------------------------------------
   // Sync/restart pin measurement
   // -----------------------------------------------------------
   ahl_pkg::ahl_rst_t rstState_r, rstState_nxt;
   logic [11:0]       lowCnt_r, lowCnt_nxt;
   logic              syncPulse_r, syncPulse_nxt;

   always_comb begin
      rstState_nxt  = rstState_r;
      lowCnt_nxt    = lowCnt_r;
      syncPulse_nxt = 1'b0;
      if (mclkInFall) begin
         case (rstState_r)
            ahl_pkg::RS_IDLE: begin
               if (!pinsSync_r.syncRstN) begin
                  rstState_nxt = ahl_pkg::RS_LOW;
                  lowCnt_nxt   = 12'h001;
               end
            end
            ahl_pkg::RS_LOW: begin
               if (pinsSync_r.syncRstN) begin
                  syncPulse_nxt = 1'b1;
                  rstState_nxt  = ahl_pkg::RS_IDLE;
                  lowCnt_nxt    = 12'h000;
               end else if (lowCnt_r == RST_LAST) begin
                  rstState_nxt  = ahl_pkg::RS_RESET;
                  lowCnt_nxt    = RST_FULL;
               end else begin
                  lowCnt_nxt    = lowCnt_r + 12'h001;
               end
            end
            ahl_pkg::RS_RESET: begin
               if (pinsSync_r.syncRstN) begin
                  rstState_nxt = ahl_pkg::RS_IDLE;
                  lowCnt_nxt   = 12'h000;
               end
            end
            default: begin
               rstState_nxt = ahl_pkg::RS_IDLE;
               lowCnt_nxt   = 12'h000;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rstState_r  <= ahl_pkg::RS_IDLE;
         lowCnt_r    <= 12'h000;
         syncPulse_r <= 1'b0;
      end else begin
         rstState_r  <= rstState_nxt;
         lowCnt_r    <= lowCnt_nxt;
         syncPulse_r <= syncPulse_nxt;
      end
   end

   assign syncPulse       = syncPulse_r;
   assign deviceResetting = (rstState_r == ahl_pkg::RS_RESET);

   // -----------------------------------------------------------
   // Power-on and default load sequencing
   // -----------------------------------------------------------
   ahl_pkg::ahl_pwr_t pwrState_r, pwrState_nxt;
   logic [16:0]       timer_r, timer_nxt;
   logic              linkReady_r;

   always_comb begin
      pwrState_nxt = pwrState_r;
      timer_nxt    = timer_r + 17'h00001;
      case (pwrState_r)
         ahl_pkg::PW_POR: begin
            if (timer_r == POR_LAST) begin
               pwrState_nxt = ahl_pkg::PW_REGLOAD;
               timer_nxt    = 17'h00000;
            end
         end
         ahl_pkg::PW_REGLOAD: begin
            if (timer_r == ACQ_LAST) begin
               pwrState_nxt = ahl_pkg::PW_READY;
               timer_nxt    = 17'h00000;
            end
         end
         default: begin
            timer_nxt = 17'h00000;
         end
      endcase
      if (deviceResetting && pwrState_r != ahl_pkg::PW_POR) begin
         pwrState_nxt = ahl_pkg::PW_REGLOAD;
         timer_nxt    = 17'h00000;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pwrState_r  <= ahl_pkg::PW_POR;
         timer_r     <= 17'h00000;
         linkReady_r <= 1'b0;
      end else begin
         pwrState_r  <= pwrState_nxt;
         timer_r     <= timer_nxt;
         linkReady_r <= (pwrState_nxt == ahl_pkg::PW_READY);
      end
   end

   assign linkReady = linkReady_r;

   // -----------------------------------------------------------
   // Serial shifters
   // -----------------------------------------------------------
   logic [WB-1:0]      txShift_r, txShift_nxt, rxShift_r, rxShift_nxt;
   logic [3:0]         txCnt_r, txCnt_nxt, rxCnt_r, rxCnt_nxt;
   logic               first_r, first_nxt, dout_r, dout_nxt;
   logic               oeN_r, oeN_nxt, pushValid_r, pushValid_nxt;
   logic               overrun_r, overrun_nxt, txTake, bufInReady;
   ahl_pkg::ahl_word_t push_r, push_nxt;

   always_comb begin
      txShift_nxt   = txShift_r;
      rxShift_nxt   = rxShift_r;
      txCnt_nxt     = txCnt_r;
      rxCnt_nxt     = rxCnt_r;
      first_nxt     = first_r;
      dout_nxt      = dout_r;
      oeN_nxt       = oeN_r;
      push_nxt      = push_r;
      pushValid_nxt = 1'b0;
      txTake        = 1'b0;
      if (!linkReady_r || pinsSync_r.csN) begin
         oeN_nxt   = 1'b1;
         dout_nxt  = 1'b0;
         txCnt_nxt = 4'h0;
         rxCnt_nxt = 4'h0;
      end else if (csFall) begin
         oeN_nxt     = 1'b0;
         txShift_nxt = txValid ? txWord : '0;
         txTake      = 1'b1;
         first_nxt   = 1'b1;
      end else begin
         if (launchEdge) begin
            dout_nxt = txShift_r[WB-1];
            if (txCnt_r == BIT_LAST) begin
               txShift_nxt = txValid ? txWord : '0;
               txTake      = 1'b1;
               txCnt_nxt   = 4'h0;
            end else begin
               txShift_nxt = {txShift_r[WB-2:0], 1'b0};
               txCnt_nxt   = txCnt_r + 4'h1;
            end
         end
         if (captureEdge) begin
            rxShift_nxt = {rxShift_r[WB-2:0], pinsSync_r.din};
            if (rxCnt_r == BIT_LAST) begin
               pushValid_nxt = 1'b1;
               push_nxt      = '{first: first_r, data: rxShift_nxt};
               first_nxt     = 1'b0;
               rxCnt_nxt     = 4'h0;
            end else begin
               rxCnt_nxt = rxCnt_r + 4'h1;
            end
         end
      end
      overrun_nxt = (overrun_r & ~deviceResetting) |
                    (pushValid_r & ~bufInReady);
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         txShift_r   <= '0;
         rxShift_r   <= '0;
         txCnt_r     <= 4'h0;
         rxCnt_r     <= 4'h0;
         first_r     <= 1'b0;
         dout_r      <= 1'b0;
         oeN_r       <= 1'b1;
         push_r      <= '0;
         pushValid_r <= 1'b0;
         overrun_r   <= 1'b0;
      end else begin
         txShift_r   <= txShift_nxt;
         rxShift_r   <= rxShift_nxt;
         txCnt_r     <= txCnt_nxt;
         rxCnt_r     <= rxCnt_nxt;
         first_r     <= first_nxt;
         dout_r      <= dout_nxt;
         oeN_r       <= oeN_nxt;
         push_r      <= push_nxt;
         pushValid_r <= pushValid_nxt;
         overrun_r   <= overrun_nxt;
      end
   end

   assign doutO     = dout_r;
   assign doutOeN   = oeN_r;
   assign txReady   = txTake;
   assign rxOverrun = overrun_r;

   ahl_word_buf u_buf (
      .mclk     (mclk),
      .reset    (reset),
      .flush    (deviceResetting),
      .inValid  (pushValid_r),
      .inReady  (bufInReady),
      .inWord   (push_r),
      .outValid (rxValid),
      .outReady (rxReady),
      .outWord  (rxWord)
   );

   // -----------------------------------------------------------
   // Sample ready pulse
   // -----------------------------------------------------------
   ahl_pkg::ahl_sample_ready_flag_t drState_r, drState_nxt;
   logic [2:0]         drCnt_r, drCnt_nxt;
   logic               pending_r, pending_nxt, flag_r;

   always_comb begin
      drState_nxt = drState_r;
      drCnt_nxt   = drCnt_r;
      pending_nxt = pending_r | convDone;
      case (drState_r)
         ahl_pkg::DR_IDLE: begin
            if (pending_r && linkReady_r && mclkInFall) begin
               drState_nxt = ahl_pkg::DR_HIGH;
               drCnt_nxt   = 3'h0;
               pending_nxt = convDone;
            end
         end
         ahl_pkg::DR_HIGH: begin
            if (mclkInFall) begin
               if (drCnt_r == HI_LAST) begin
                  drState_nxt = ahl_pkg::DR_LOW;
                  drCnt_nxt   = 3'h0;
               end else begin
                  drCnt_nxt = drCnt_r + 3'h1;
               end
            end
         end
         default: begin
            if (mclkInFall) begin
               if (drCnt_r == LO_LAST) begin
                  drState_nxt = ahl_pkg::DR_IDLE;
                  drCnt_nxt   = 3'h0;
                  if (pending_r && linkReady_r) begin
                     drState_nxt = ahl_pkg::DR_HIGH;
                     pending_nxt = convDone;
                  end
               end else begin
                  drCnt_nxt = drCnt_r + 3'h1;
               end
            end
         end
      endcase
      if (deviceResetting) begin
         drState_nxt = ahl_pkg::DR_IDLE;
         drCnt_nxt   = 3'h0;
         pending_nxt = convDone;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         drState_r <= ahl_pkg::DR_IDLE;
         drCnt_r   <= 3'h0;
         pending_r <= 1'b0;
         flag_r    <= 1'b0;
      end else begin
         drState_r <= drState_nxt;
         drCnt_r   <= drCnt_nxt;
         pending_r <= pending_nxt;
         flag_r    <= (drState_nxt == ahl_pkg::DR_HIGH);
      end
   end

   assign sampleReadyFlag = flag_r;

   // -----------------------------------------------------------
   // Checks
   // -----------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);

   chk_sync_pulse_len:
   assert property (syncPulse_r |-> $past(lowCnt_r) >= 12'h001 &&
                    $past(lowCnt_r) <= 12'(`AHL_SYNC_MAX_PERIODS))
      else $error("sync pulse outside 1 to 2047 periods");
   chk_reset_entry:
   assert property ((rstState_r == ahl_pkg::RS_LOW && lowCnt_r == RST_LAST
                     && mclkInFall && !pinsSync_r.syncRstN)
                    |=> deviceResetting && !syncPulse ##1 !linkReady)
      else $error("long low did not reset the device");
   chk_fall_sampling:
   assert property ($changed(lowCnt_r) |-> $past(mclkInFall))
      else $error("low counter moved without master clock fall");
   chk_flag_high_len:
   assert property (($fell(sampleReadyFlag) && !$past(deviceResetting))
                    |-> $past(mclkInFall) && $past(drCnt_r) == HI_LAST)
      else $error("ready flag high phase wrong length");
   chk_por_delay:
   assert property ((pwrState_r == ahl_pkg::PW_POR && timer_r != POR_LAST)
                    |=> pwrState_r == ahl_pkg::PW_POR && !linkReady)
      else $error("power-on wait ended early");
   chk_regload_delay:
   assert property ((pwrState_r == ahl_pkg::PW_REGLOAD ##1
                     pwrState_r == ahl_pkg::PW_READY)
                    |-> $past(timer_r) == ACQ_LAST)
      else $error("default load time wrong");
   chk_capture_edge:
   assert property ($changed(rxShift_r) |-> $past(captureEdge))
      else $error("data in taken off the falling clock");
   chk_launch_edge:
   assert property (($changed(doutO) && !doutOeN && $past(!doutOeN))
                    |-> $past(launchEdge))
      else $error("data out moved off the rising clock");
   chk_oe_release:
   assert property (pinsSync_r.csN |=> doutOeN)
      else $error("data out driven while deselected");
   chk_low_saturate:
   assert property (lowCnt_r <= RST_FULL)
      else $error("low counter passed saturation");

   cov_sync: cover property (syncPulse_r);
   cov_reset: cover property ($rose(deviceResetting));
   cov_word: cover property (rxValid && rxReady);
   cov_ready: cover property ($rose(sampleReadyFlag));
endmodule // ahl_host_link

//--- tb/ahl_host_model.sv
// Purpose: Host bus master model driving the serial port
// Assumes: Called through its tasks from the bench
// Notes:   Half period of 16 mclk gives a 160 ns link clock
`timescale 1ns/1ps
module ahl_host_model (
   input  wire logic mclk,
   output      logic sclk,
   output      logic csN,
   output      logic din,
   input  wire logic dout
);
   initial begin
      sclk = 1'b0;
      csN  = 1'b1;
      din  = 1'b0;
   end

   task automatic half();
      repeat (16) @(posedge mclk);
   endtask

   // Select or release, clock held low
   task automatic sel(input logic lvl);
      half();
      csN <= lvl;
      if (lvl)
         din <= ~din;
      half();
   endtask

   // Launch on rise, device captures on fall
   task automatic word(input logic [15:0] w, output logic [15:0] got);
      for (int i = 15; i >= 0; i--) begin
         sclk <= 1'b1;
         din  <= w[i];
         half();
         got[i] = dout;
         sclk <= 1'b0;
         half();
      end
   endtask
endmodule // ahl_host_model

//--- tb/ahl_host_link_tb.sv
// Purpose: Self-checking bench of the host link
// Assumes: POR_CYCLES shortened to 20
// Notes:   Master clock input pin runs at a tenth of mclk
`timescale 1ns/1ps
module ahl_host_link_tb;
   localparam int POR = 20;
   logic               mclk, reset, mclkInPin, syncRstNPin;
   logic               sclk, csN, din, doutO, doutOeN, dout;
   logic               sampleReadyFlag, convDone, txValid, txReady;
   logic               rxValid, rxReady, syncPulse, deviceResetting;
   logic               linkReady, rxOverrun, prevF;
   logic [15:0]        txArr [8];
   logic [15:0]        dinW [3];
   logic [2:0]         txIdx;
   logic [3:0]         div;
   ahl_pkg::ahl_word_t rxWord;
   integer             seed = 32'he171c4ee;
   int                 errors, n_compared, n, s0, cyc, nSync, nRst;
   int                 hiCnt, loCnt, hiLast, loLast;

   assign dout = doutOeN ? 1'bz : doutO;

   ahl_host_link #(.POR_CYCLES(POR)) i_dut (
      .mclk(mclk), .reset(reset), .mclkInPin(mclkInPin),
      .syncRstNPin(syncRstNPin), .sclkPin(sclk), .csNPin(csN),
      .dinPin(din), .doutO(doutO), .doutOeN(doutOeN),
      .sampleReadyFlag(sampleReadyFlag), .convDone(convDone),
      .txWord(txArr[txIdx]), .txValid(txValid), .txReady(txReady),
      .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady),
      .syncPulse(syncPulse), .deviceResetting(deviceResetting),
      .linkReady(linkReady), .rxOverrun(rxOverrun));

   ahl_host_model i_host (
      .mclk(mclk), .sclk(sclk), .csN(csN), .din(din), .dout(dout));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // Monitors and stimulus clocks
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      div <= (div == 4'h4) ? 4'h0 : div + 4'h1;
      if (div == 4'h4)
         mclkInPin <= ~mclkInPin;
      if (txReady === 1'b1)
         txIdx <= txIdx + 3'h1;
      nSync <= nSync + int'(syncPulse === 1'b1);
      nRst  <= nRst + int'(deviceResetting === 1'b1);
      prevF <= sampleReadyFlag;
      if (sampleReadyFlag === 1'b1) begin
         if (!prevF)
            loLast <= loCnt;
         hiCnt <= hiCnt + 1;
         loCnt <= 0;
      end else begin
         if (prevF)
            hiLast <= hiCnt;
         loCnt <= loCnt + 1;
         hiCnt <= 0;
      end
      if (cyc == 60000) begin
         errors++;
         stop_test();
      end
   end

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask

   task automatic stop_test();
      $display("errors=%0d n_compared=%0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   function automatic logic [15:0] exp_tx(input logic [2:0] i);
      return txArr[i];
   endfunction

   task automatic frame(input int nw);
      logic [15:0] got;
      logic [2:0]  k;
      k = txIdx;
      i_host.sel(1'b0);
      chk(doutOeN, 1'b0);
      for (int w = 0; w < nw; w++) begin
         dinW[w] = $random(seed);
         i_host.word(dinW[w], got);
         chk(got, exp_tx(k + w[2:0]));
      end
      i_host.sel(1'b1);
      chk(doutOeN, 1'b1);
   endtask

   task automatic pop(input logic [15:0] d, input logic f);
      #1;
      chk(rxValid, 1'b1);
      chk(rxWord, {f, d});
      @(posedge mclk) rxReady <= 1'b1;
      @(posedge mclk) rxReady <= 1'b0;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      {reset, syncRstNPin, txValid, mclkInPin, convDone} = 5'h1c;
      {rxReady, prevF, txIdx, div} = '0;
      {errors, n_compared, cyc, nSync, nRst} = '0;
      {hiCnt, loCnt, hiLast, loLast} = '0;
      for (int i = 0; i < 8; i++)
         txArr[i] = $random(seed);
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      for (n = 0; n < 3000 && linkReady !== 1'b1; n++) @(posedge mclk);
      chk(n >= POR + 998 && n <= POR + 1004, 1);
      frame(3);
      chk(rxOverrun, 1'b1);
      pop(dinW[0], 1'b1);
      pop(dinW[1], 1'b0);
      #1 chk(rxValid, 1'b0);
      @(posedge mclk) convDone <= 1'b1;
      @(posedge mclk) convDone <= 1'b0;
      repeat (10) @(posedge mclk);
      convDone <= 1'b1;
      @(posedge mclk) convDone <= 1'b0;
      repeat (150) @(posedge mclk);
      chk(hiLast >= 38 && hiLast <= 42, 1);
      chk(loLast >= 38 && loLast <= 44, 1);
      s0 = nSync;
      syncRstNPin <= 1'b0;
      repeat (50) @(posedge mclk);
      syncRstNPin <= 1'b1;
      repeat (60) @(posedge mclk);
      chk(nSync - s0, 1);
      chk(nRst, 0);
      syncRstNPin <= 1'b0;
      repeat (20600) @(posedge mclk);
      chk(deviceResetting, 1'b1);
      chk({linkReady, rxOverrun}, 2'h0);
      syncRstNPin <= 1'b1;
      for (n = 0; n < 2000 && linkReady !== 1'b1; n++) @(posedge mclk);
      chk(n >= 995 && n <= 1030, 1);
      chk(nSync - s0, 1);
      frame(1);
      pop(dinW[0], 1'b1);
      stop_test();
   end
endmodule // ahl_host_link_tb
